// ===== bsl_pkg.sv
// constants and types shared by the boot strap latch
// Contract
// - five strap pins, each captured as one configuration bit
// - captured strap bits readable by software through a read-only register
// - straps sampled as 0 or 1 on every system reset cause
// - latched straps stay fixed until the next reset or power-down
// - weak pulls applied during reset: down on ldo and qualifier, up on others
// - after reset the strap pins return to their functional role
// - latched ldo strap picks flash supply: 0 is 3.3 V, 1 is 1.8 V
// - boot select 1 means flash boot; 0 with qualifier 0 means download
// - log strap 1 lets boot log toggle uart0 transmit, 0 keeps it silent
// - log and sdio straps pick sdio input and output edges, 1 means rising
// - firmware may override flash supply and sdio edges after boot
// - chip power-up pin high runs the chip, low holds it in reset
`default_nettype none
package bsl_pkg;
    localparam int          BSL_NUM_STRAPS   = 5;
    localparam int          BSL_ADDR_W       = 4;
    localparam int          BSL_DATA_W       = 32;
    // register offsets
    localparam logic [3:0]  BSL_OFF_STRAP    = 4'h0;
    localparam logic [3:0]  BSL_OFF_OVERRIDE = 4'h4;
    localparam logic [3:0]  BSL_OFF_STATUS   = 4'h8;
    // override register fields
    localparam int          BSL_OVR_W        = 5;
    localparam int          BSL_OVR_LDO_EN   = 0;
    localparam int          BSL_OVR_LDO_VAL  = 1;
    localparam int          BSL_OVR_SDIO_EN  = 2;
    localparam int          BSL_OVR_SDIO_IN  = 3;
    localparam int          BSL_OVR_SDIO_OUT = 4;
    localparam logic [4:0]  BSL_OVR_RESET    = 5'h00;
    // status register fields
    localparam int          BSL_ST_VALID     = 0;
    localparam int          BSL_ST_FLASH_1V8 = 1;
    localparam int          BSL_ST_BOOT      = 2;
    localparam int          BSL_ST_LOG_EN    = 4;
    localparam int          BSL_ST_SDIO_IN   = 5;
    localparam int          BSL_ST_SDIO_OUT  = 6;
    // pull defaults, bit order as in the strap register: 1 is pull-up
    localparam logic [4:0]  BSL_STRAP_PULL_UP = 5'h1a;
    localparam logic [4:0]  BSL_STRAP_PULL_DN = 5'h05;
    // timing
    localparam int          BSL_CLK_HZ         = 10_000_000;
    localparam int          BSL_PU_LOW_MIN_US  = 200;
    localparam int          BSL_PU_LOW_CYCLES  = BSL_PU_LOW_MIN_US * (BSL_CLK_HZ / 1_000_000);
    localparam logic [2:0]  BSL_SETTLE_CYCLES  = 3'h3;   // pin synchroniser depth plus one

    typedef struct packed {
        logic sdio_edge;
        logic log_timing;
        logic dl_qualifier;
        logic boot_select;
        logic ldo_voltage;
    } bsl_strap_s;

    typedef enum logic [1:0] {
        BSL_BOOT_FLASH    = 2'b00,
        BSL_BOOT_DOWNLOAD = 2'b01,
        BSL_BOOT_UNDEF    = 2'b10
    } bsl_boot_e;

    typedef enum logic {
        BSL_PH_RESET = 1'b0,
        BSL_PH_RUN   = 1'b1
    } bsl_phase_e;
endpackage : bsl_pkg
`default_nettype wire

// ===== bsl_boot_strap_latch.sv
// boot strap latch: samples strap pins during system reset and serves them to software
`timescale 1ns/1ps
`default_nettype none
module bsl_boot_strap_latch #(
    parameter int PU_LOW_CYCLES = bsl_pkg::BSL_PU_LOW_CYCLES
) (
    input  wire logic                          clk_i,
    input  wire logic                          nrst_i,
    input  wire logic                          chip_power_up_pin_i,
    input  wire logic                          rtc_wdt_rst_i,
    input  wire logic                          brownout_rst_i,
    input  wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] strap_pad_i,
    input  wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] func_out_i,
    input  wire logic [bsl_pkg::BSL_NUM_STRAPS-1:0] func_oe_i,
    output var  logic [bsl_pkg::BSL_NUM_STRAPS-1:0] strap_pad_o,
    output var  logic [bsl_pkg::BSL_NUM_STRAPS-1:0] strap_pad_oe_o,
    output var  logic [bsl_pkg::BSL_NUM_STRAPS-1:0] pull_up_en_o,
    output var  logic [bsl_pkg::BSL_NUM_STRAPS-1:0] pull_down_en_o,
    output var  logic [bsl_pkg::BSL_NUM_STRAPS-1:0] func_in_o,
    input  wire logic [bsl_pkg::BSL_ADDR_W-1:0]     addr_i,
    input  wire logic [bsl_pkg::BSL_DATA_W-1:0]     wdata_i,
    input  wire logic                          wr_i,
    input  wire logic                          rd_i,
    output var  logic [bsl_pkg::BSL_DATA_W-1:0]     rdata_o,
    output var  logic                          strap_valid_o,
    output var  logic                          sys_rst_o,
    output var  logic                          flash_1v8_sel_o,
    output var  bsl_pkg::bsl_boot_e            boot_mode_o,
    output var  logic                          uart_log_en_o,
    output var  logic                          sdio_in_rise_o,
    output var  logic                          sdio_out_rise_o
);
    import bsl_pkg::*;

    // the low-time counter is 16 bits wide
    if (PU_LOW_CYCLES < 1 || PU_LOW_CYCLES > 65535) begin : g_bad_param
        $error("PU_LOW_CYCLES out of range");
    end

    localparam logic [15:0] PU_LIMIT = 16'(PU_LOW_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisers

    logic                     rst_meta;
    logic                     rst_n;
    logic [BSL_NUM_STRAPS-1:0] strap_meta;
    logic [BSL_NUM_STRAPS-1:0] strap_sync;
    logic                     pu_meta;
    logic                     pu_sync;

    // power-on reset is released through two flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // straps and power-up pin come from the board, so two flops each
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= BSL_STRAP_PULL_UP;
            strap_sync <= BSL_STRAP_PULL_UP;
            pu_meta    <= 1'b1;
            pu_sync    <= 1'b1;
        end else begin
            strap_meta <= strap_pad_i;
            strap_sync <= strap_meta;
            pu_meta    <= chip_power_up_pin_i;
            pu_sync    <= pu_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system reset sources and phase

    logic [15:0] pu_low_cnt;
    logic        pu_hold;
    logic        sys_rst_req;
    logic [2:0]  settle_cnt;
    bsl_phase_e  phase;

    // a short glitch on the power-up pin must not reset the chip
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pu_low_cnt <= 16'h0000;
        end else if (pu_sync) begin
            pu_low_cnt <= 16'h0000;
        end else if (pu_low_cnt != PU_LIMIT) begin
            pu_low_cnt <= pu_low_cnt + 16'h0001;
        end
    end

    assign pu_hold     = (pu_low_cnt == PU_LIMIT);
    assign sys_rst_req = pu_hold | rtc_wdt_rst_i | brownout_rst_i;

    // reset phase lasts while a cause is present, then long enough to settle the pins
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 3'h0;
            phase      <= BSL_PH_RESET;
        end else if (sys_rst_req) begin
            settle_cnt <= 3'h0;
            phase      <= BSL_PH_RESET;
        end else if (phase == BSL_PH_RESET) begin
            if (settle_cnt == BSL_SETTLE_CYCLES) begin
                phase <= BSL_PH_RUN;
            end else begin
                settle_cnt <= settle_cnt + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // strap latch

    bsl_strap_s strap;
    logic       valid;

    // track the pins while in reset; freeze the last sample when running
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap <= bsl_strap_s'(BSL_STRAP_PULL_UP);
            valid <= 1'b0;
        end else if (phase == BSL_PH_RESET) begin
            strap <= bsl_strap_s'(strap_sync);
            valid <= 1'b0;
        end else begin
            valid <= 1'b1; // strap held
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad control: pulls during reset, functional use afterwards

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_pad_o    <= 5'h00;
            strap_pad_oe_o <= 5'h00;
            pull_up_en_o   <= BSL_STRAP_PULL_UP;
            pull_down_en_o <= BSL_STRAP_PULL_DN;
            func_in_o      <= 5'h00;
        end else if (phase == BSL_PH_RESET) begin
            strap_pad_o    <= 5'h00;
            strap_pad_oe_o <= 5'h00;              // pins left to board and pulls
            pull_up_en_o   <= BSL_STRAP_PULL_UP;
            pull_down_en_o <= BSL_STRAP_PULL_DN;
            func_in_o      <= 5'h00;
        end else begin
            strap_pad_o    <= func_out_i;
            strap_pad_oe_o <= func_oe_i;
            pull_up_en_o   <= 5'h00;
            pull_down_en_o <= 5'h00;
            func_in_o      <= strap_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // firmware override register

    logic [BSL_OVR_W-1:0] ovr;
    logic                 wr_ovr;

    // writes during reset are dropped; every system reset restores strap control
    assign wr_ovr = wr_i && (addr_i == BSL_OFF_OVERRIDE) && (phase == BSL_PH_RUN);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ovr <= BSL_OVR_RESET;
        end else if (phase == BSL_PH_RESET) begin
            ovr <= BSL_OVR_RESET;
        end else if (wr_ovr) begin
            ovr <= wdata_i[BSL_OVR_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // derived boot settings

    bsl_boot_e next_boot_mode;

    // qualifier high with boot select low is not a legal pair
    always_comb begin
        if (strap.boot_select) begin
            next_boot_mode = BSL_BOOT_FLASH;
        end else if (!strap.dl_qualifier) begin
            next_boot_mode = BSL_BOOT_DOWNLOAD;
        end else begin
            next_boot_mode = BSL_BOOT_UNDEF;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            flash_1v8_sel_o <= 1'b0;
            boot_mode_o     <= BSL_BOOT_FLASH;
            uart_log_en_o   <= 1'b0;
            sdio_in_rise_o  <= 1'b0;
            sdio_out_rise_o <= 1'b0;
            strap_valid_o   <= 1'b0;
            sys_rst_o       <= 1'b1;
        end else begin
            flash_1v8_sel_o <= ovr[BSL_OVR_LDO_EN] ? ovr[BSL_OVR_LDO_VAL] : strap.ldo_voltage;
            boot_mode_o     <= next_boot_mode;
            uart_log_en_o   <= strap.log_timing;
            sdio_in_rise_o  <= ovr[BSL_OVR_SDIO_EN] ? ovr[BSL_OVR_SDIO_IN] : strap.log_timing;
            sdio_out_rise_o <= ovr[BSL_OVR_SDIO_EN] ? ovr[BSL_OVR_SDIO_OUT] : strap.sdio_edge;
            strap_valid_o   <= valid;
            sys_rst_o       <= (phase == BSL_PH_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe

    logic [BSL_DATA_W-1:0] next_rdata;

    // unmapped offsets read zero
    always_comb begin
        next_rdata = '0;
        unique case (addr_i)
            BSL_OFF_STRAP: begin
                next_rdata[BSL_NUM_STRAPS-1:0] = strap;
            end
            BSL_OFF_OVERRIDE: begin
                next_rdata[BSL_OVR_W-1:0] = ovr;
            end
            BSL_OFF_STATUS: begin
                next_rdata[BSL_ST_VALID]          = strap_valid_o;
                next_rdata[BSL_ST_FLASH_1V8]      = flash_1v8_sel_o;
                next_rdata[BSL_ST_BOOT +: 2]      = boot_mode_o;
                next_rdata[BSL_ST_LOG_EN]         = uart_log_en_o;
                next_rdata[BSL_ST_SDIO_IN]        = sdio_in_rise_o;
                next_rdata[BSL_ST_SDIO_OUT]       = sdio_out_rise_o;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions and covers

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    strap_capture_a : assert property ((phase == BSL_PH_RESET) |=> strap == $past(strap_sync))
        else $error("strap not captured during reset");

    strap_hold_a : assert property (((phase == BSL_PH_RUN) && $past(phase) == BSL_PH_RUN) |-> $stable(strap))
        else $error("strap changed while running");

    strap_read_a : assert property ((rd_i && addr_i == BSL_OFF_STRAP)
                                    |=> rdata_o == {27'h0, $past(strap)})
        else $error("strap register readback wrong");

    ldo_select_a : assert property (!ovr[BSL_OVR_LDO_EN] |=> flash_1v8_sel_o == $past(strap.ldo_voltage))
        else $error("flash supply select does not follow strap");

    boot_flash_a : assert property (strap.boot_select |=> boot_mode_o == BSL_BOOT_FLASH)
        else $error("flash boot not selected");

    boot_download_a : assert property ((!strap.boot_select && !strap.dl_qualifier)
                                       |=> boot_mode_o == BSL_BOOT_DOWNLOAD)
        else $error("download boot not selected");

    uart_log_a : assert property ($changed(strap.log_timing) |=> uart_log_en_o == $past(strap.log_timing))
        else $error("log enable does not follow strap");

    sdio_edge_a : assert property (!ovr[BSL_OVR_SDIO_EN]
                                   |=> {sdio_in_rise_o, sdio_out_rise_o}
                                       == {$past(strap.log_timing), $past(strap.sdio_edge)})
        else $error("sdio edges do not follow straps");

    reset_pulls_a : assert property ((phase == BSL_PH_RESET)
                                     |=> pull_up_en_o == BSL_STRAP_PULL_UP && strap_pad_oe_o == 5'h00)
        else $error("pulls not applied in reset");

    pin_release_a : assert property ((phase == BSL_PH_RUN) |=> strap_pad_oe_o == $past(func_oe_i))
        else $error("strap pin not returned to function");

    power_up_hold_a : assert property ((!pu_sync && pu_low_cnt == PU_LIMIT - 16'h0001)
                                       ##1 !pu_sync |=> phase == BSL_PH_RESET)
        else $error("power-up pin low did not hold reset");

    override_a : assert property ((wr_ovr && wdata_i[BSL_OVR_SDIO_EN]) ##1 (phase == BSL_PH_RUN && !sys_rst_req)
                                  |=> sdio_in_rise_o == $past(wdata_i[BSL_OVR_SDIO_IN], 2))
        else $error("sdio override not applied");

    run_entry_c : cover property ((phase == BSL_PH_RESET) ##1 (phase == BSL_PH_RUN));
    download_c  : cover property ((phase == BSL_PH_RUN) && boot_mode_o == BSL_BOOT_DOWNLOAD);
    override_c  : cover property (wr_ovr && wdata_i[BSL_OVR_LDO_EN]);
    wdt_reset_c : cover property ((phase == BSL_PH_RUN) ##1 rtc_wdt_rst_i);

endmodule : bsl_boot_strap_latch
`default_nettype wire

// ===== bsl_strap_board.sv
// board-side model of the strap pins: host gpio drive, weak pulls, floating pads
`timescale 1ns/1ps
`default_nettype none
module bsl_strap_board (
    input  wire logic       clk_i,
    input  wire logic [4:0] host_drv_i,
    input  wire logic [4:0] host_val_i,
    input  wire logic [4:0] pad_out_i,
    input  wire logic [4:0] pad_oe_i,
    input  wire logic [4:0] pull_up_i,
    input  wire logic [4:0] pull_dn_i,
    output var  logic [4:0] pad_o
);
    logic [4:0] float_q = 5'h00;
    // a pad nobody holds wanders every cycle, so no one can rely on a stale level
    always_ff @(posedge clk_i) begin
        float_q <= ~pad_o;
    end
    // wire level: chip driver first, then host gpio, then the weak pulls
    always_comb begin
        for (int b = 0; b < 5; b++) begin
            if (pad_oe_i[b]) begin
                pad_o[b] = pad_out_i[b];
            end else if (host_drv_i[b]) begin
                pad_o[b] = host_val_i[b];
            end else if (pull_up_i[b]) begin
                pad_o[b] = 1'b1;
            end else if (pull_dn_i[b]) begin
                pad_o[b] = 1'b0;
            end else begin
                pad_o[b] = float_q[b];
            end
        end
    end
endmodule : bsl_strap_board
`default_nettype wire

// ===== bsl_boot_strap_latch_test.sv
// self-checking bench for the boot strap latch: capture, reset causes, registers
`timescale 1ns/1ps
`default_nettype none
module bsl_boot_strap_latch_test;
    import bsl_pkg::*;
    localparam int PU_LOW = 8;  // short power-up low time keeps the run brief
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        pu_pin = 1'b1;
    logic        wdt_rst = 1'b0;
    logic        bo_rst = 1'b0;
    logic [4:0]  host_drv = 5'h00;
    logic [4:0]  host_val = 5'h00;
    logic [4:0]  f_out = 5'h00;
    logic [4:0]  f_oe = 5'h00;
    logic [4:0]  pad, pad_out, pad_oe, pu_en, pd_en, f_in;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        valid, sys_rst, f18, log_en, in_r, out_r, glitch;
    bsl_boot_e   boot;
    int          n_fail = 0;
    int          total_checks = 0;

    bsl_boot_strap_latch #(.PU_LOW_CYCLES(PU_LOW)) i_dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .chip_power_up_pin_i(pu_pin),
        .rtc_wdt_rst_i(wdt_rst), .brownout_rst_i(bo_rst), .strap_pad_i(pad),
        .func_out_i(f_out), .func_oe_i(f_oe), .strap_pad_o(pad_out),
        .strap_pad_oe_o(pad_oe), .pull_up_en_o(pu_en), .pull_down_en_o(pd_en),
        .func_in_o(f_in), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .strap_valid_o(valid), .sys_rst_o(sys_rst),
        .flash_1v8_sel_o(f18), .boot_mode_o(boot), .uart_log_en_o(log_en),
        .sdio_in_rise_o(in_r), .sdio_out_rise_o(out_r));
    bsl_strap_board i_board (
        .clk_i(clk_i), .host_drv_i(host_drv), .host_val_i(host_val),
        .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pull_up_i(pu_en),
        .pull_dn_i(pd_en), .pad_o(pad));

    ////////////////////////////////////////////////////////////////////////////
    // clock and helpers
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    // bus strobes last one cycle; read data is taken in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask : reg_rd
    function automatic logic [1:0] boot_of(input logic [4:0] s);
        return s[1] ? 2'b00 : (s[2] ? 2'b10 : 2'b01);
    endfunction : boot_of
    // bounded wait for the reset phase to end, then one cycle for derived outputs
    task automatic wait_run();
        int k;
        k = 0;
        while (sys_rst !== 1'b0 && k < 40) begin
            tick(1);
            k++;
        end
        // the valid flag trails the end of the reset phase by one cycle; a hang leaves it low
        tick(1);
        chk({31'h0, valid}, 32'h1);
    endtask : wait_run
    task automatic check_straps(input logic [4:0] s);
        reg_rd(BSL_OFF_STRAP, d);
        chk(d, {27'h0, s});
        reg_rd(BSL_OFF_STATUS, d);
        chk(d, {25'h0, s[4], s[3], s[3], boot_of(s), s[0], 1'b1});
        chk({26'h0, f18, boot, log_en, in_r, out_r}, {26'h0, s[0], boot_of(s), s[3], s[3], s[4]});
    endtask : check_straps
    // causes: 0 watchdog, 1 brownout, 2 power-up pin held low past its minimum
    task automatic sys_reset(input int cause);
        @(posedge clk_i);
        wdt_rst <= (cause == 0);
        bo_rst <= (cause == 1);
        pu_pin <= (cause != 2);
        repeat (cause == 2 ? PU_LOW + 6 : 3) @(posedge clk_i);
        wdt_rst <= 1'b0;
        bo_rst <= 1'b0;
        pu_pin <= 1'b1;
        #1;
        chk({31'h0, sys_rst}, 32'h1);
        wait_run();
    endtask : sys_reset

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (7) @(posedge clk_i);
        #1;
        chk({17'h0, pu_en, pd_en, pad_oe}, {17'h0, 5'h1a, 5'h05, 5'h00});
        @(posedge clk_i);
        nrst_i <= 1'b1;
        tick(1);
        wait_run();
        check_straps(5'h1a);
        @(posedge clk_i);
        f_oe <= 5'h1f;
        f_out <= 5'h15;
        tick(2);
        chk({12'h0, pad_oe, pad_out, pu_en, pd_en}, {12'h0, 5'h1f, 5'h15, 10'h0});
        @(posedge clk_i);
        f_oe <= 5'h00;
        host_drv <= 5'h1f;
        host_val <= 5'h05;
        tick(5);
        chk({27'h0, f_in}, 32'h05);
        reg_wr(BSL_OFF_STRAP, 32'hffff_ffff);
        reg_wr(BSL_OFF_STATUS, 32'hffff_ffff);
        check_straps(5'h1a);
        reg_rd(4'hc, d);
        chk(d, 32'h0);
        for (int i = 0; i < 32; i++) begin
            host_val <= 5'(i);
            tick(3);
            sys_reset(i % 3);
            check_straps(5'(i));
        end
        host_val <= 5'h01;
        tick(3);
        sys_reset(0);
        reg_wr(BSL_OFF_OVERRIDE, 32'h1d);
        reg_rd(BSL_OFF_OVERRIDE, d);
        chk(d, 32'h1d);
        chk({29'h0, f18, in_r, out_r}, 32'h3);
        sys_reset(1);
        reg_rd(BSL_OFF_OVERRIDE, d);
        chk(d, 32'h0);
        check_straps(5'h01);
        // a short low pulse on the power-up pin must not reset the chip
        @(posedge clk_i);
        pu_pin <= 1'b0;
        repeat (3) @(posedge clk_i);
        pu_pin <= 1'b1;
        glitch = 1'b0;
        repeat (12) begin
            tick(1);
            glitch = glitch | (sys_rst !== 1'b0);
        end
        chk({31'h0, glitch}, 32'h0);
        wrap_up();
    end
    // watchdog: the run needs roughly 800 cycles
    initial begin
        repeat (6000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
endmodule : bsl_boot_strap_latch_test
`default_nettype wire
